// File: scl_event_flags.sv
// sticky status flags, set by hardware events and cleared by their own events
`timescale 1ns/1ps
`default_nettype none
module scl_event_flags #(
    parameter int N = scl_pkg::SCL_NUM_FLAGS
) (
    // clock, enable and global reset
    input  wire logic         mclk_i,
    input  wire logic         ce_i,
    input  wire logic         global_reset_n_i,
    // per-flag set and clear
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    // flag levels
    output logic [N-1:0]      flags_o
);
    import scl_pkg::*;

    typedef struct packed {
        logic [N-1:0] flags;
    } scl_flag_state_type;

    scl_flag_state_type st_r;
    scl_flag_state_type st_nxt;
    logic [N-1:0]       flag_nxt;

    // set wins over a clear in the same cycle
    for (genvar i = 0; i < N; i++) begin : g_flag
        assign flag_nxt[i] = set_i[i] | (st_r.flags[i] & ~clr_i[i]);
    end

    // next state, global reset clears every flag
    always_comb begin
        st_nxt = st_r;
        if (!global_reset_n_i) begin
            st_nxt.flags = N'(SCL_FLAGS_RST);
        end else if (ce_i) begin
            st_nxt.flags = flag_nxt;
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign flags_o = st_r.flags;
endmodule
`default_nettype wire

// File: scl_pin_select.sv
// shared wake / ring output pin: source choice and drive enable
`timescale 1ns/1ps
`default_nettype none
module scl_pin_select (
    // clock, enable and global reset
    input  wire logic mclk_i,
    input  wire logic ce_i,
    input  wire logic global_reset_n_i,
    // selection
    input  wire logic wake_ring_pin_select_i,
    input  wire logic ring_output_enable_i,
    // sources
    input  wire logic pme_i,
    input  wire logic ring_indicate_output_i,
    // pin drive
    output logic      pin_o,
    output logic      pin_oe_o
);
    import scl_pkg::*;

    typedef struct packed {
        logic pin;
        logic oe;
    } scl_pin_state_type;

    scl_pin_state_type st_r;
    scl_pin_state_type st_nxt;

    // wake source when selected, else ring when enabled, else released
    always_comb begin
        st_nxt = st_r;
        if (!global_reset_n_i) begin
            st_nxt.pin = SCL_RSVD_ZERO_VAL;
            st_nxt.oe  = SCL_RSVD_ZERO_VAL;
        end else if (ce_i) begin
            if (wake_ring_pin_select_i) begin
                st_nxt.pin = pme_i;
                st_nxt.oe  = 1'b1;
            end else if (ring_output_enable_i) begin
                st_nxt.pin = ring_indicate_output_i;
                st_nxt.oe  = 1'b1;
            end else begin
                st_nxt.pin = SCL_RSVD_ZERO_VAL;
                st_nxt.oe  = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign pin_o    = st_r.pin;
    assign pin_oe_o = st_r.oe;
endmodule
`default_nettype wire

// File: scl_pkg.sv
// package: constants, field layout and carrier types of the system control register
package scl_pkg;

    // config space decode
    localparam logic [7:0]  SCL_SYS_CTRL_OFS    = 8'h80;
    localparam logic [2:0]  SCL_GLOBAL_FUNC     = 3'h0;

    // field positions in the 32-bit word
    localparam int          SCL_RSVD_RW_LSB     = 16;
    localparam int          SCL_RSVD_RW_MSB     = 20;
    localparam int          SCL_BIT_BURST_DN    = 15;
    localparam int          SCL_BIT_BURST_UP    = 14;
    localparam int          SCL_BIT_SOCK_ACT    = 13;
    localparam int          SCL_BIT_RSVD_ONE    = 12;
    localparam int          SCL_BIT_PWR_STREAM  = 11;
    localparam int          SCL_BIT_UP_DELAY    = 10;
    localparam int          SCL_BIT_DOWN_DELAY  = 9;
    localparam int          SCL_BIT_CARD_QUERY  = 8;
    localparam int          SCL_BIT_RSVD_ZERO7  = 7;
    localparam int          SCL_BIT_LOW_POWER   = 6;
    localparam int          SCL_BIT_SUBSYS_LOCK = 5;
    localparam int          SCL_BIT_PAR_SERR    = 4;
    localparam int          SCL_BIT_RSVD_ZERO3  = 3;
    localparam int          SCL_BIT_LEGACY_VOLT = 2;
    localparam int          SCL_BIT_CLK_KEEP    = 1;
    localparam int          SCL_BIT_PIN_SEL     = 0;

    // byte lanes holding the low fields
    localparam int          SCL_BE_LANE0        = 0;
    localparam int          SCL_BE_LANE1        = 1;
    localparam int          SCL_BE_LANE2        = 2;

    // reset values of the writable fields
    localparam logic [4:0]  SCL_RSVD_RW_RST     = 5'h00;
    localparam logic        SCL_BURST_DN_RST    = 1'b1;
    localparam logic        SCL_BURST_UP_RST    = 1'b0;
    localparam logic        SCL_LOW_POWER_RST   = 1'b1;
    localparam logic        SCL_SUBSYS_LOCK_RST = 1'b1;
    localparam logic        SCL_PAR_SERR_RST    = 1'b0;
    localparam logic        SCL_CLK_KEEP_RST    = 1'b0;
    localparam logic        SCL_PIN_SEL_RST     = 1'b0;
    localparam logic        SCL_LEGACY_VOLT_RST = 1'b0;
    localparam logic        SCL_RSVD_ONE_VAL    = 1'b1;
    localparam logic        SCL_RSVD_ZERO_VAL   = 1'b0;
    localparam logic [31:0] SCL_WORD_ZERO       = 32'h0000_0000;

    // hardware-set status flags, index order
    localparam int          SCL_NUM_FLAGS       = 5;
    localparam int          SCL_FLG_SOCK_ACT    = 0;
    localparam int          SCL_FLG_PWR_STREAM  = 1;
    localparam int          SCL_FLG_UP_DELAY    = 2;
    localparam int          SCL_FLG_DOWN_DELAY  = 3;
    localparam int          SCL_FLG_CARD_QUERY  = 4;
    localparam logic [SCL_NUM_FLAGS-1:0] SCL_FLAGS_RST = 5'h00;

    // configuration access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  func;
        logic [7:0]  offset;
        logic [3:0]  be;
        logic [31:0] wdata;
    } scl_cfg_req_type;

    // events from the socket and power-switch logic
    typedef struct packed {
        logic card_access;
        logic stream_start;
        logic stream_done;
        logic up_sent;
        logic up_settled;
        logic down_sent;
        logic down_settled;
        logic query_start;
        logic query_done;
    } scl_evt_type;

    // control levels driven into the rest of the device
    typedef struct packed {
        logic downstream_read_burst_en;
        logic upstream_read_burst_en;
        logic low_power_en;
        logic subsys_id_write_lock;
        logic cardbus_parity_to_serr_en;
        logic clock_keep_alive;
    } scl_ctrl_type;

endpackage

// File: scl_sys_ctrl.sv
// low half of the system control register: fields, status and config access
// Overview of operation
// - bit 15 enables downstream memory read bursting; resets to enabled.
// - bit 14 enables upstream memory read bursting; resets to disabled.
// - bit 13 sets on any PC Card access, clears on a read that enables byte lane 1.
// - bit 12 always reads one; bits 7 and 3 always read zero.
// - bit 11 high while a power change streams, until the stream is done.
// - bit 10 set after a power-up stream, until power-up settling delay ends.
// - bit 9 set after a power-down stream, until power-down settling delay ends.
// - bit 8 high while a card interrogation runs, low when it completes.
// - bit 6 selects reduced-power mode; resets to one.
// - bit 5 locks function 2 subsystem ID writes; one locks, reset one.
// - bit 4 routes CardBus data parity errors onto SERR; reset off.
// - bit 2 shows legacy card voltage: zero 3.3 V, one 5 V.
// - bit 1 keeps PCI and CardBus clocks running via clock-run protocol.
// - bit 0 picks wake output, else ring output if enabled, else released.
// - fields return to defaults only on global reset, not bus reset.
// - power-management context bits 10, 9, 8 clear only on global reset.
`timescale 1ns/1ps
`default_nettype none
module scl_sys_ctrl (
    // clock, enable and resets
    input  wire logic                   mclk_i,
    input  wire logic                   ce_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   global_reset_n_i,
    // configuration access
    input  wire scl_pkg::scl_cfg_req_type cfg_req_i,
    output logic [31:0]                 cfg_rdata_o,
    output logic                        cfg_rvalid_o,
    // hardware events and levels
    input  wire scl_pkg::scl_evt_type   evt_i,
    input  wire logic                   legacy_5v_sel_i,
    input  wire logic                   ring_output_enable_i,
    input  wire logic                   pme_i,
    input  wire logic                   ring_indicate_output_i,
    // control outputs
    output scl_pkg::scl_ctrl_type       ctrl_o,
    // shared wake / ring pin
    output logic                        wake_ring_pin_o,
    output logic                        wake_ring_pin_oe_o
);
    import scl_pkg::*;

    // state of this module; the flags and pin state live in u_flags and u_pin
    typedef struct packed {
        logic [4:0]   rsvd_rw;
        logic         burst_dn;
        logic         burst_up;
        logic         low_power;
        logic         subsys_lock;
        logic         par_serr;
        logic         clk_keep;
        logic         pin_sel;
        logic         legacy_volt;
        logic [31:0]  rdata;
        logic         rvalid;
        scl_ctrl_type ctrl;
    } scl_state_type;

    scl_state_type           st_r;
    scl_state_type           st_nxt;
    logic [SCL_NUM_FLAGS-1:0] flag_set;
    logic [SCL_NUM_FLAGS-1:0] flag_clr;
    logic [SCL_NUM_FLAGS-1:0] flags;
    logic                    hit;
    logic                    wr_hit;
    logic                    rd_hit;
    logic [31:0]             word;

    // decode: only the function 0 copy of the register answers
    assign hit    = (cfg_req_i.offset == SCL_SYS_CTRL_OFS)
                  && (cfg_req_i.func == SCL_GLOBAL_FUNC);
    assign wr_hit = hit & cfg_req_i.wr & ce_i;
    assign rd_hit = hit & cfg_req_i.rd & ce_i;

    // flag events; activity read-clear only counts a read that sees lane 1
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[SCL_FLG_SOCK_ACT]   = evt_i.card_access;
        flag_clr[SCL_FLG_SOCK_ACT]   = rd_hit & cfg_req_i.be[SCL_BE_LANE1];
        flag_set[SCL_FLG_PWR_STREAM] = evt_i.stream_start;
        flag_clr[SCL_FLG_PWR_STREAM] = evt_i.stream_done;
        flag_set[SCL_FLG_UP_DELAY]   = evt_i.up_sent;
        flag_clr[SCL_FLG_UP_DELAY]   = evt_i.up_settled;
        flag_set[SCL_FLG_DOWN_DELAY] = evt_i.down_sent;
        flag_clr[SCL_FLG_DOWN_DELAY] = evt_i.down_settled;
        flag_set[SCL_FLG_CARD_QUERY] = evt_i.query_start;
        flag_clr[SCL_FLG_CARD_QUERY] = evt_i.query_done;
    end

    // status flags, context bits cleared by global reset alone
    scl_event_flags #(
        .N                (SCL_NUM_FLAGS)
    ) u_flags (
        .mclk_i           (mclk_i),
        .ce_i             (ce_i),
        .global_reset_n_i (global_reset_n_i),
        .set_i            (flag_set),
        .clr_i            (flag_clr),
        .flags_o          (flags)
    );

    // shared pin driver
    scl_pin_select u_pin (
        .mclk_i                 (mclk_i),
        .ce_i                   (ce_i),
        .global_reset_n_i       (global_reset_n_i),
        .wake_ring_pin_select_i (st_r.pin_sel),
        .ring_output_enable_i   (ring_output_enable_i),
        .pme_i                  (pme_i),
        .ring_indicate_output_i (ring_indicate_output_i),
        .pin_o                  (wake_ring_pin_o),
        .pin_oe_o               (wake_ring_pin_oe_o)
    );

    // assemble the read word; upper bits read zero
    always_comb begin
        word = SCL_WORD_ZERO;
        word[SCL_RSVD_RW_MSB:SCL_RSVD_RW_LSB] = st_r.rsvd_rw;
        word[SCL_BIT_BURST_DN]    = st_r.burst_dn;
        word[SCL_BIT_BURST_UP]    = st_r.burst_up;
        word[SCL_BIT_SOCK_ACT]    = flags[SCL_FLG_SOCK_ACT];
        word[SCL_BIT_RSVD_ONE]    = SCL_RSVD_ONE_VAL;
        word[SCL_BIT_PWR_STREAM]  = flags[SCL_FLG_PWR_STREAM];
        word[SCL_BIT_UP_DELAY]    = flags[SCL_FLG_UP_DELAY];
        word[SCL_BIT_DOWN_DELAY]  = flags[SCL_FLG_DOWN_DELAY];
        word[SCL_BIT_CARD_QUERY]  = flags[SCL_FLG_CARD_QUERY];
        word[SCL_BIT_RSVD_ZERO7]  = SCL_RSVD_ZERO_VAL;
        word[SCL_BIT_LOW_POWER]   = st_r.low_power;
        word[SCL_BIT_SUBSYS_LOCK] = st_r.subsys_lock;
        word[SCL_BIT_PAR_SERR]    = st_r.par_serr;
        word[SCL_BIT_RSVD_ZERO3]  = SCL_RSVD_ZERO_VAL;
        word[SCL_BIT_LEGACY_VOLT] = st_r.legacy_volt;
        word[SCL_BIT_CLK_KEEP]    = st_r.clk_keep;
        word[SCL_BIT_PIN_SEL]     = st_r.pin_sel;
    end

    // next state of fields, read port and control outputs
    always_comb begin
        st_nxt = st_r;
        if (!global_reset_n_i) begin
            // fields take their defaults on global reset only
            st_nxt.rsvd_rw     = SCL_RSVD_RW_RST;
            st_nxt.burst_dn    = SCL_BURST_DN_RST;
            st_nxt.burst_up    = SCL_BURST_UP_RST;
            st_nxt.low_power   = SCL_LOW_POWER_RST;
            st_nxt.subsys_lock = SCL_SUBSYS_LOCK_RST;
            st_nxt.par_serr    = SCL_PAR_SERR_RST;
            st_nxt.clk_keep    = SCL_CLK_KEEP_RST;
            st_nxt.pin_sel     = SCL_PIN_SEL_RST;
            st_nxt.legacy_volt = SCL_LEGACY_VOLT_RST;
            st_nxt.rdata       = SCL_WORD_ZERO;
            st_nxt.rvalid      = 1'b0;
            st_nxt.ctrl        = '{
                downstream_read_burst_en:  SCL_BURST_DN_RST,
                upstream_read_burst_en:    SCL_BURST_UP_RST,
                low_power_en:              SCL_LOW_POWER_RST,
                subsys_id_write_lock:      SCL_SUBSYS_LOCK_RST,
                cardbus_parity_to_serr_en: SCL_PAR_SERR_RST,
                clock_keep_alive:          SCL_CLK_KEEP_RST};
        end else if (!rst_n_i) begin
            // bus reset only drops the read port, fields are kept
            st_nxt.rdata  = SCL_WORD_ZERO;
            st_nxt.rvalid = 1'b0;
        end else if (ce_i) begin
            // voltage status follows the legacy power control
            st_nxt.legacy_volt = legacy_5v_sel_i;
            // writable fields by byte lane; status bits have no write path
            if (wr_hit && cfg_req_i.be[SCL_BE_LANE2]) begin
                st_nxt.rsvd_rw = cfg_req_i.wdata[SCL_RSVD_RW_MSB:SCL_RSVD_RW_LSB];
            end
            if (wr_hit && cfg_req_i.be[SCL_BE_LANE1]) begin
                st_nxt.burst_dn = cfg_req_i.wdata[SCL_BIT_BURST_DN];
                st_nxt.burst_up = cfg_req_i.wdata[SCL_BIT_BURST_UP];
            end
            if (wr_hit && cfg_req_i.be[SCL_BE_LANE0]) begin
                st_nxt.low_power   = cfg_req_i.wdata[SCL_BIT_LOW_POWER];
                st_nxt.subsys_lock = cfg_req_i.wdata[SCL_BIT_SUBSYS_LOCK];
                st_nxt.par_serr    = cfg_req_i.wdata[SCL_BIT_PAR_SERR];
                st_nxt.clk_keep    = cfg_req_i.wdata[SCL_BIT_CLK_KEEP];
                st_nxt.pin_sel     = cfg_req_i.wdata[SCL_BIT_PIN_SEL];
            end
            // bits 13..8, 12, 7, 3, 2 ignore the write data entirely
            // read answers one cycle later; misses read zero
            st_nxt.rvalid = cfg_req_i.rd & ce_i;
            st_nxt.rdata  = rd_hit ? word : SCL_WORD_ZERO;
            // control outputs follow the stored fields
            st_nxt.ctrl.downstream_read_burst_en  = st_r.burst_dn;
            st_nxt.ctrl.upstream_read_burst_en    = st_r.burst_up;
            st_nxt.ctrl.low_power_en              = st_r.low_power;
            st_nxt.ctrl.subsys_id_write_lock      = st_r.subsys_lock;
            st_nxt.ctrl.cardbus_parity_to_serr_en = st_r.par_serr;
            st_nxt.ctrl.clock_keep_alive          = st_r.clk_keep;
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    // outputs straight from flip-flops
    assign cfg_rdata_o  = st_r.rdata;
    assign cfg_rvalid_o = st_r.rvalid;
    assign ctrl_o       = st_r.ctrl;
endmodule
`default_nettype wire

// File: scl_sys_ctrl_chk.sv
// assertion checker for the low system control fields
`timescale 1ns/1ps
`default_nettype none
module scl_sys_ctrl_chk import scl_pkg::*; (
    // clock, enable and resets
    input wire logic                     mclk_i,
    input wire logic                     ce_i,
    input wire logic                     rst_n_i,
    input wire logic                     global_reset_n_i,
    // config access
    input wire scl_pkg::scl_cfg_req_type cfg_req_i,
    input wire logic [31:0]              cfg_rdata_o,
    input wire logic                     cfg_rvalid_o,
    // events and levels
    input wire scl_pkg::scl_evt_type     evt_i,
    input wire logic                     legacy_5v_sel_i,
    input wire logic                     ring_output_enable_i,
    input wire logic                     pme_i,
    input wire logic                     ring_indicate_output_i,
    // controls and pin
    input wire scl_pkg::scl_ctrl_type    ctrl_o,
    input wire logic                     wake_ring_pin_o,
    input wire logic                     wake_ring_pin_oe_o
);
    // decode of the register hit and the low write lane
    logic       hit;
    logic       wr_hit;
    logic [3:0] lo_bits;
    assign hit     = cfg_req_i.offset == SCL_SYS_CTRL_OFS && cfg_req_i.func == SCL_GLOBAL_FUNC;
    assign wr_hit  = ce_i && cfg_req_i.wr && hit;
    assign lo_bits = {cfg_req_i.wdata[6:4], cfg_req_i.wdata[1]};

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!global_reset_n_i || !rst_n_i);

    // read answers and fixed bits
    a_read_answer: assert property (
        $past(ce_i || !rst_n_i || !global_reset_n_i) |->
        cfg_rvalid_o == $past(ce_i && cfg_req_i.rd && rst_n_i && global_reset_n_i))
        else $error("read answer pulse wrong");
    a_rsvd_fixed: assert property (
        cfg_rvalid_o && $past(ce_i) && $past(hit) |->
        cfg_rdata_o[12] && !cfg_rdata_o[7] && !cfg_rdata_o[3])
        else $error("fixed bits wrong");
    a_miss_zero: assert property (
        cfg_rvalid_o && $past(ce_i) && !$past(hit) |-> cfg_rdata_o == SCL_WORD_ZERO)
        else $error("miss read not zero");
    // status flags
    a_sock_set: assert property (
        (ce_i && evt_i.card_access) ##1 (ce_i && cfg_req_i.rd && hit) |=> cfg_rdata_o[13])
        else $error("activity flag not set");
    a_sock_clear: assert property (
        (ce_i && cfg_req_i.rd && hit && cfg_req_i.be[1] && !evt_i.card_access) ##1
        !evt_i.card_access ##1 (ce_i && cfg_req_i.rd && hit) |=> !cfg_rdata_o[13])
        else $error("activity flag not cleared");
    a_stream_set: assert property (
        (ce_i && evt_i.stream_start) ##1 (ce_i && cfg_req_i.rd && hit) |=> cfg_rdata_o[11])
        else $error("stream flag not set");
    a_down_set: assert property (
        (ce_i && evt_i.down_sent) ##1 (ce_i && cfg_req_i.rd && hit) |=> cfg_rdata_o[9])
        else $error("down delay flag not set");
    // control levels follow written fields
    a_ctrl_low: assert property (
        (wr_hit && cfg_req_i.be[0]) ##1 ce_i |=> {ctrl_o.low_power_en, ctrl_o.subsys_id_write_lock,
        ctrl_o.cardbus_parity_to_serr_en, ctrl_o.clock_keep_alive} == $past(lo_bits, 2))
        else $error("low lane controls wrong");
    a_ctrl_burst: assert property (
        (wr_hit && cfg_req_i.be[1]) ##1 ce_i |=> {ctrl_o.downstream_read_burst_en,
        ctrl_o.upstream_read_burst_en} == $past(cfg_req_i.wdata[15:14], 2))
        else $error("burst enables wrong");
    // shared pin
    a_pin_wake: assert property (
        (wr_hit && cfg_req_i.be[0] && cfg_req_i.wdata[0]) ##1 ce_i |=>
        wake_ring_pin_oe_o && wake_ring_pin_o == $past(pme_i))
        else $error("pin not carrying wake");
    a_pin_release: assert property (
        (wr_hit && cfg_req_i.be[0] && !cfg_req_i.wdata[0]) ##1 (ce_i && !ring_output_enable_i)
        |=> !wake_ring_pin_oe_o)
        else $error("pin not released");
    // reset scope
    a_bus_rst_keep: assert property (
        disable iff (!global_reset_n_i)
        (!rst_n_i && !cfg_req_i.wr) ##1 (!rst_n_i && !cfg_req_i.wr) |=> $stable(ctrl_o))
        else $error("bus reset touched fields");
    a_global_reset_n_dflt: assert property (
        $rose(global_reset_n_i) |-> ctrl_o == 6'h2c && !wake_ring_pin_oe_o)
        else $error("global reset defaults wrong");

    // main scenarios
    c_sock_read: cover property (cfg_rvalid_o && cfg_rdata_o[13]);
    c_stream_done: cover property (ce_i && evt_i.stream_done);
    c_bus_rst: cover property (!rst_n_i && global_reset_n_i);
endmodule

bind scl_sys_ctrl scl_sys_ctrl_chk scl_sys_ctrl_chk_inst (
    .mclk_i(mclk_i), .ce_i(ce_i), .rst_n_i(rst_n_i), .global_reset_n_i(global_reset_n_i),
    .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .evt_i(evt_i), .legacy_5v_sel_i(legacy_5v_sel_i),
    .ring_output_enable_i(ring_output_enable_i), .pme_i(pme_i),
    .ring_indicate_output_i(ring_indicate_output_i), .ctrl_o(ctrl_o),
    .wake_ring_pin_o(wake_ring_pin_o), .wake_ring_pin_oe_o(wake_ring_pin_oe_o)
);
`default_nettype wire

// File: tb.sv
// self-checking bench for the low system control fields
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scl_pkg::*;
    // design connections
    logic mclk_i, ce_i, rst_n_i, global_reset_n_i;
    logic legacy_5v_sel_i, ring_output_enable_i, pme_i, ring_indicate_output_i;
    logic cfg_rvalid_o, wake_ring_pin_o, wake_ring_pin_oe_o;
    logic [31:0] cfg_rdata_o;
    scl_cfg_req_type cfg_req_i;
    scl_evt_type evt_i;
    scl_ctrl_type ctrl_o;
    // bench bookkeeping
    int mismatches;
    int compares;
    logic [31:0] exp_w, seed, r;
    logic [31:0] rq[$];

    scl_sys_ctrl scl_sys_ctrl_inst (
        .mclk_i(mclk_i), .ce_i(ce_i), .rst_n_i(rst_n_i), .global_reset_n_i(global_reset_n_i),
        .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .evt_i(evt_i), .legacy_5v_sel_i(legacy_5v_sel_i),
        .ring_output_enable_i(ring_output_enable_i), .pme_i(pme_i),
        .ring_indicate_output_i(ring_indicate_output_i), .ctrl_o(ctrl_o),
        .wake_ring_pin_o(wake_ring_pin_o), .wake_ring_pin_oe_o(wake_ring_pin_oe_o)
    );

    // 10 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // compare of read words and of output levels
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] exp);
        cmp_word({24'h00_0000, got}, {24'h00_0000, exp});
    endtask

    // xorshift source and expected-value helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] wmask(input logic [3:0] be);
        return (be[0] ? 32'h0000_0073 : 32'h0000_0000) | (be[1] ? 32'h0000_c000 : 32'h0000_0000)
             | (be[2] ? 32'h001f_0000 : 32'h0000_0000);
    endfunction
    function automatic logic [7:0] lvl();
        return {exp_w[15:14], exp_w[6:4], exp_w[1], exp_w[0] | ring_output_enable_i,
                exp_w[0] ? pme_i : (ring_output_enable_i & ring_indicate_output_i)};
    endfunction

    // one config access, noting the expected read word
    task automatic acc(input logic rd, input logic wr, input logic [31:0] d,
                       input logic [3:0] be, input logic [7:0] ofs, input logic [2:0] fn);
        logic hit;
        @(negedge mclk_i);
        hit = ce_i && ofs == SCL_SYS_CTRL_OFS && fn == SCL_GLOBAL_FUNC;
        // reserved field is always written back unchanged
        d[SCL_RSVD_RW_MSB:SCL_RSVD_RW_LSB] = exp_w[SCL_RSVD_RW_MSB:SCL_RSVD_RW_LSB];
        cfg_req_i = '{rd: rd, wr: wr, func: fn, offset: ofs, be: be, wdata: d};
        evt_i = '0;
        if (rd && ce_i) rq.push_back(hit ? exp_w : SCL_WORD_ZERO);
        if (rd && hit && be[1]) exp_w[13] = 1'b0;
        if (wr && hit) exp_w = (exp_w & ~wmask(be)) | (d & wmask(be));
        @(negedge mclk_i);
        cfg_req_i.rd = 1'b0;
        cfg_req_i.wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] be);
        acc(1'b1, 1'b0, SCL_WORD_ZERO, be, SCL_SYS_CTRL_OFS, SCL_GLOBAL_FUNC);
    endtask
    task automatic wr(input logic [31:0] d);
        acc(1'b0, 1'b1, d, 4'hf, SCL_SYS_CTRL_OFS, SCL_GLOBAL_FUNC);
    endtask
    // event pulse, then a read in the very next cycle
    task automatic pulse(input int k, input int fb, input logic v);
        @(negedge mclk_i);
        evt_i = scl_evt_type'(9'h001 << k);
        exp_w[fb] = v;
        rd(4'h1);
    endtask
    task automatic chk_lvl();
        repeat (2) @(negedge mclk_i);
        cmp_lvl({ctrl_o, wake_ring_pin_oe_o, wake_ring_pin_o}, lvl());
    endtask

    // read answers checked against the oldest note
    always @(negedge mclk_i) begin
        if (cfg_rvalid_o === 1'b1) begin
            cmp_word(cfg_rdata_o, (rq.size() > 0) ? rq.pop_front() : 32'hxxxx_xxxx);
        end
    end

    task automatic conclude();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge mclk_i);
        mismatches++;
        $display("watchdog expired");
        conclude();
    end

    // main sequence
    initial begin
        mismatches = 0;
        compares = 0;
        seed = 32'h0000_0025;
        exp_w = 32'h0000_9060;
        {ce_i, rst_n_i, global_reset_n_i} = 3'h4;
        {legacy_5v_sel_i, ring_output_enable_i, pme_i, ring_indicate_output_i} = 4'h0;
        cfg_req_i = '0;
        evt_i = '0;
        repeat (12) @(negedge mclk_i);
        rst_n_i = 1'b1;
        global_reset_n_i = 1'b1;
        rd(4'hf);
        chk_lvl();
        $display("reset values test done");
        pme_i = 1'b1;
        wr(32'hffff_ffff);
        rd(4'hf);
        chk_lvl();
        wr(32'h0000_0000);
        rd(4'hf);
        chk_lvl();
        $display("field write test done");
        for (int k = 0; k < 4; k++) begin
            pulse(7 - 2 * k, 11 - k, 1'b1);
            wr(32'h0000_0000);
            rd(4'hf);
            pulse(6 - 2 * k, 11 - k, 1'b0);
        end
        pulse(8, 13, 1'b1);
        rd(4'hf);
        rd(4'hf);
        $display("status flag test done");
        pulse(7, 11, 1'b1);
        wr(32'h0000_c073);
        rst_n_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        rst_n_i = 1'b1;
        rd(4'hf);
        chk_lvl();
        legacy_5v_sel_i = 1'b1;
        exp_w[2] = 1'b1;
        rd(4'hf);
        // let the read answer drop before freezing, else it is held
        @(negedge mclk_i);
        ce_i = 1'b0;
        wr(32'h0000_0000);
        rd(4'hf);
        ce_i = 1'b1;
        rd(4'hf);
        $display("bus reset and voltage test done");
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            {ring_output_enable_i, pme_i, ring_indicate_output_i} = r[10:8];
            acc(1'b0, 1'b1, rnd(), r[3:0], r[4] ? SCL_SYS_CTRL_OFS : r[31:24],
                r[5] ? SCL_GLOBAL_FUNC : r[14:12]);
            acc(1'b1, 1'b0, SCL_WORD_ZERO, r[19:16], r[20] ? SCL_SYS_CTRL_OFS : r[31:24],
                r[21] ? SCL_GLOBAL_FUNC : r[14:12]);
            chk_lvl();
        end
        $display("random access test done");
        legacy_5v_sel_i = 1'b0;
        global_reset_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        global_reset_n_i = 1'b1;
        exp_w = 32'h0000_9060;
        rd(4'hf);
        chk_lvl();
        cmp_word(32'(rq.size()), 32'h0000_0000);
        $display("global reset test done");
        conclude();
    end
endmodule
`default_nettype wire
